// ==== pkg/pic_pkg.sv ====
/*
 * Shared constants and types for the parallel drive port controller.
 * Assumes one 25 MHz clock and an I/O requester that holds its request
 * until the controller acknowledges it.
 */
// Functional notes
// - Data port 16-bit, other registers 8-bit
// - Control offsets 0,1 reserved; 2 alt; 3 forwarded
// - Claim every access in enabled ranges
// - Shadow drive-select bit per connector
// - Fast timing only for data port
// - One fast mode per connector, per drive
// - Enhanced: separate timing for drive 1
// - Startup latency before first strobe
// - Shutdown latency after last strobe
// - Back-to-back data transfers skip start/shutdown
// - Strobe width 2 to 5 clocks
// - Recovery 1 to 4 clocks
// - Ready low extends strobe, synchronised
// - ISA recovery ignored while fast mode on
// - Ready forced per drive by setting
// - 32-bit data access splits in two
// - Two independent bus master channels
// - Descriptor 8 bytes; zero count is 64K
// - Table end bit stops after retire
// - Address incrementer spans bits 1 to 15
// - Register access asserts select, compatible strobes
// - Command 8 bytes, control 4, upper zero
// - Start fetches descriptor; requests masked till loaded
// - Last region done clears active, masks request
package pic_pkg;

	////////////////////////////////////////////////////////////////////////
	// Address map
	localparam logic [15:0] CMD_BASE_PRI = 16'h01f0;
	localparam logic [15:0] CTL_BASE_PRI = 16'h03f4;
	localparam logic [15:0] CMD_BASE_SEC = 16'h0170;
	localparam logic [15:0] CTL_BASE_SEC = 16'h0374;
	localparam logic [2:0] REG_DATA = 3'h0;
	localparam logic [2:0] REG_DRIVE_HEAD = 3'h6;
	localparam logic [2:0] CTL_ALT_STATUS = 3'h2;
	localparam logic [2:0] CTL_FLOPPY = 3'h3;
	localparam int DRIVE_SEL_BIT = 4;

	////////////////////////////////////////////////////////////////////////
	// Timing configuration fields; drive 1 fields sit TIM_DRIVE_STEP higher
	localparam int TIM_FAST = 0;
	localparam int TIM_RDY_FORCE = 1;
	localparam int TIM_DWORD = 2;
	localparam int TIM_DRIVE_STEP = 4;
	localparam int TIM_RECOV_LO = 8;
	localparam int TIM_STROBE_LO = 12;
	localparam int TIM_SEPARATE = 14;
	localparam int TIM_DECODE_EN = 15;
	localparam int SEC_RECOV_LO = 0;
	localparam int SEC_STROBE_LO = 2;
	localparam logic [3:0] STROBE_MIN_CYC = 4'h2;
	localparam logic [3:0] RECOV_MIN_CYC = 4'h1;

	////////////////////////////////////////////////////////////////////////
	// Compatible timing, rounded up to whole clocks
	localparam int CLK_NS = 40;
	localparam int CMP_STROBE_NS = 290;
	localparam int CMP_RECOV_NS = 310;
	localparam int SETUP_NS = 70;
	localparam int HOLD_NS = 30;
	localparam int ISA_RECOV_NS = 80;
	localparam logic [3:0] CMP_STROBE_CYC = 4'((CMP_STROBE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] CMP_RECOV_CYC = 4'((CMP_RECOV_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] ISA_RECOV_CYC = 4'((ISA_RECOV_NS + CLK_NS - 1) / CLK_NS);
	// One extra clock leaves a window for a back-to-back request
	localparam logic [3:0] SHUTDOWN_CYC = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS + 1);

	////////////////////////////////////////////////////////////////////////
	// Descriptors
	localparam logic [31:0] DESC_BYTES = 32'h0000_0008;
	localparam logic [31:0] DESC_CNT_OFS = 32'h0000_0004;
	localparam int TABLE_END_BIT = 31;
	localparam logic [16:0] FULL_REGION = 17'h1_0000;
	localparam logic [16:0] WORD_BYTES = 17'h0_0002;

	typedef enum logic [2:0] {
		E_IDLE, E_SETUP, E_STROBE, E_WAIT, E_RECOV, E_HOLD
	} pic_eng_type;

	typedef enum logic [1:0] {
		C_IDLE, C_FETCH_ADDR, C_FETCH_CNT, C_XFER
	} pic_chan_type;

endpackage

// ==== pkg/pic_bm_if.sv ====
/*
 * Link between the controller core and one bus master channel.
 * Assumes the core arbitrates the shared memory port.
 */
`timescale 1ns/1ns
interface pic_bm_if;
	logic start;
	logic to_mem;
	logic [31:0] table_ptr;
	logic drq;
	logic req;
	logic fetch;
	logic wr;
	logic [31:0] addr;
	logic ack;
	logic [31:0] rdata;
	logic active;
	logic dma_ack;

	modport chan (
		input start, to_mem, table_ptr, drq, ack, rdata,
		output req, fetch, wr, addr, active, dma_ack
	);
	modport host (
		output start, to_mem, table_ptr, drq, ack, rdata,
		input req, fetch, wr, addr, active, dma_ack
	);
endinterface

// ==== logic/pic_bm_chan.sv ====
/*
 * One bus master channel: walks the descriptor table and moves words.
 * Assumes the host side holds ack low until it has served req.
 */
`timescale 1ns/1ns
module pic_bm_chan (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Core link
	pic_bm_if.chan bm
);

	typedef struct packed {
		pic_pkg::pic_chan_type st;
		logic start_q;
		logic active;
		logic [31:0] cur_addr;
		logic [16:0] cur_cnt;
		logic table_end;
		logic [31:0] ptr;
		logic drq_s1;
		logic drq_s2;
		logic req;
		logic fetch;
		logic wr;
		logic [31:0] req_addr;
		logic dma_ack;
	} pic_chan_state_type;

	pic_chan_state_type q, d;

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		d = q;
		d.drq_s1 = bm.drq;
		d.drq_s2 = q.drq_s1;
		d.start_q = bm.start;
		if (!bm.start)
		begin
			// Software stop aborts at once
			d.st = pic_pkg::C_IDLE;
			d.active = 1'b0;
			d.req = 1'b0;
			d.dma_ack = 1'b0;
		end
		else
		begin
			unique case (q.st)
				pic_pkg::C_IDLE:
					if (!q.start_q)
					begin
						// Rising start fetches the first descriptor
						d.ptr = bm.table_ptr;
						d.active = 1'b1;
						d.req = 1'b1;
						d.fetch = 1'b1;
						d.wr = 1'b0;
						d.req_addr = bm.table_ptr;
						d.st = pic_pkg::C_FETCH_ADDR;
					end
				pic_pkg::C_FETCH_ADDR:
					if (bm.ack)
					begin
						d.cur_addr = {bm.rdata[31:1], 1'b0};
						d.req_addr = q.ptr + pic_pkg::DESC_CNT_OFS;
						d.st = pic_pkg::C_FETCH_CNT;
					end
				pic_pkg::C_FETCH_CNT:
					if (bm.ack)
					begin
						// Zero count means a full region
						d.cur_cnt = (bm.rdata[15:0] == 16'h0000) ?
							pic_pkg::FULL_REGION : {1'b0, bm.rdata[15:0]};
						d.table_end = bm.rdata[pic_pkg::TABLE_END_BIT];
						d.ptr = q.ptr + pic_pkg::DESC_BYTES;
						d.req = 1'b0;
						d.st = pic_pkg::C_XFER;
					end
				pic_pkg::C_XFER:
					if (q.req)
					begin
						if (bm.ack)
						begin
							d.req = 1'b0;
							d.dma_ack = 1'b0;
							// Region never crosses 64K
							d.cur_addr[15:1] = q.cur_addr[15:1] + 15'h0001;
							d.cur_cnt = q.cur_cnt - pic_pkg::WORD_BYTES;
							if (q.cur_cnt <= pic_pkg::WORD_BYTES)
							begin
								if (q.table_end)
								begin
									d.active = 1'b0;
									d.st = pic_pkg::C_IDLE;
								end
								else
								begin
									d.req = 1'b1;
									d.fetch = 1'b1;
									d.wr = 1'b0;
									d.req_addr = q.ptr;
									d.st = pic_pkg::C_FETCH_ADDR;
								end
							end
						end
					end
					else if (q.drq_s2)
					begin
						// Drive request only honoured once loaded
						d.req = 1'b1;
						d.fetch = 1'b0;
						d.wr = bm.to_mem;
						d.req_addr = q.cur_addr;
						d.dma_ack = 1'b1;
					end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign bm.req = q.req;
	assign bm.fetch = q.fetch;
	assign bm.wr = q.wr;
	assign bm.addr = q.req_addr;
	assign bm.active = q.active;
	assign bm.dma_ack = q.dma_ack;

endmodule

// ==== logic/pic_ctrl.sv ====
/*
 * Drive port controller: register decode, programmed I/O timing engine,
 * read return buffer and two bus master channels.
 * Assumes the I/O requester holds io_req until io_ack and drops it the
 * cycle after; drive pins are resolved outside.
 */
`timescale 1ns/1ns
module pic_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Configuration
	input wire logic io_space_en,
	input wire logic [1:0][15:0] drive_timing_cfg,
	input wire logic [1:0][3:0] second_drive_timing_cfg,
	input wire logic isa_recovery_en,
	// I/O target
	input wire logic io_req,
	input wire logic io_write,
	input wire logic io_dword,
	input wire logic [31:0] io_addr,
	input wire logic [31:0] io_wdata,
	output logic io_claim,
	output logic io_ack,
	output logic isa_forward,
	// Read return
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [31:0] rd_data,
	// Drive cables
	output logic [1:0] command_block_select_n,
	output logic [1:0] control_block_select_n,
	output logic [2:0] drive_register_addr,
	output logic [1:0] drive_read_strobe_n,
	output logic [1:0] drive_write_strobe_n,
	input wire logic [15:0] drive_data_in,
	output logic [15:0] drive_data_out,
	output logic drive_data_oe,
	input wire logic [1:0] drive_ready_in,
	// Bus master
	input wire logic [1:0] bm_start,
	input wire logic [1:0] bm_to_mem,
	input wire logic [1:0][31:0] bm_table_ptr,
	output logic [1:0] busmaster_channel_status,
	input wire logic [1:0] drive_dma_request,
	output logic [1:0] drive_dma_ack,
	output logic mem_req,
	output logic mem_fetch,
	output logic mem_write,
	output logic [31:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata
);

	typedef struct packed {
		pic_pkg::pic_eng_type st;
		logic [3:0] cnt;
		logic ch;
		logic is_read;
		logic is_data;
		logic is_ctl;
		logic two_half;
		logic half;
		logic force_rdy;
		logic [3:0] width;
		logic [3:0] recov;
		logic [2:0] reg_off;
		logic [31:0] wdata;
		logic [31:0] acc;
		logic [1:0] drive_sel;
		logic [1:0] rdy_s1;
		logic [1:0] rdy_s2;
		logic [15:0] din_s1;
		logic [15:0] din_s2;
		logic ack;
		logic fwd;
		logic rd_stb;
		logic wr_stb;
		logic oe;
		logic [15:0] dout;
		logic [1:0][31:0] buf_word;
		logic [1:0] buf_cnt;
		logic buf_wp;
		logic buf_rp;
		logic gnt;
		logic busy;
	} pic_ctrl_state_type;

	pic_ctrl_state_type q, d;

	////////////////////////////////////////////////////////////////////////
	// Decode of the incoming request
	logic [1:0] en;
	logic [1:0] cmd_hit;
	logic [1:0] ctl_hit;
	logic n_ch;
	logic n_ctl;
	logic [2:0] n_off;
	logic n_drv;
	logic n_data;
	logic n_fast;
	logic [15:0] n_cfg;
	logic [1:0] n_stb_sel;
	logic [1:0] n_rcv_sel;
	logic any_fast;
	logic buf_room;
	logic start_ok;

	// Upper address half must be zero
	assign en[0] = io_space_en && drive_timing_cfg[0][pic_pkg::TIM_DECODE_EN];
	assign en[1] = io_space_en && drive_timing_cfg[1][pic_pkg::TIM_DECODE_EN];
	assign cmd_hit[0] = en[0]
		&& io_addr[31:3] == {16'h0000, pic_pkg::CMD_BASE_PRI[15:3]};
	assign cmd_hit[1] = en[1]
		&& io_addr[31:3] == {16'h0000, pic_pkg::CMD_BASE_SEC[15:3]};
	assign ctl_hit[0] = en[0]
		&& io_addr[31:2] == {16'h0000, pic_pkg::CTL_BASE_PRI[15:2]};
	assign ctl_hit[1] = en[1]
		&& io_addr[31:2] == {16'h0000, pic_pkg::CTL_BASE_SEC[15:2]};
	// Claim without looking at byte enables
	assign io_claim = io_req && (|cmd_hit || |ctl_hit);

	assign n_ch = cmd_hit[1] || ctl_hit[1];
	assign n_ctl = |ctl_hit;
	assign n_off = n_ctl ? {1'b0, io_addr[1:0]} : io_addr[2:0];
	assign n_drv = q.drive_sel[n_ch];
	assign n_cfg = drive_timing_cfg[n_ch];
	assign n_data = !n_ctl && n_off == pic_pkg::REG_DATA;
	// Fast timing only for the data port of a selected drive
	assign n_fast = n_data
		&& n_cfg[pic_pkg::TIM_FAST + pic_pkg::TIM_DRIVE_STEP * n_drv];
	// Drive 1 may use the second timing set
	assign n_stb_sel = (n_drv && n_cfg[pic_pkg::TIM_SEPARATE]) ?
		second_drive_timing_cfg[n_ch][pic_pkg::SEC_STROBE_LO +: 2] :
		n_cfg[pic_pkg::TIM_STROBE_LO +: 2];
	assign n_rcv_sel = (n_drv && n_cfg[pic_pkg::TIM_SEPARATE]) ?
		second_drive_timing_cfg[n_ch][pic_pkg::SEC_RECOV_LO +: 2] :
		n_cfg[pic_pkg::TIM_RECOV_LO +: 2];
	assign any_fast = drive_timing_cfg[0][pic_pkg::TIM_FAST]
		|| drive_timing_cfg[0][pic_pkg::TIM_FAST + pic_pkg::TIM_DRIVE_STEP]
		|| drive_timing_cfg[1][pic_pkg::TIM_FAST]
		|| drive_timing_cfg[1][pic_pkg::TIM_FAST + pic_pkg::TIM_DRIVE_STEP];
	// A read waits for room in the return buffer
	assign buf_room = q.buf_cnt != 2'h2;
	assign start_ok = io_claim && !q.ack && (io_write || buf_room);

	////////////////////////////////////////////////////////////////////////
	// Bus master channels
	pic_bm_if bm0 ();
	pic_bm_if bm1 ();

	// One instance per connector
	pic_bm_chan u_chan0 (
		.clk (clk),
		.rst_n (rst_n),
		.bm (bm0.chan)
	);
	pic_bm_chan u_chan1 (
		.clk (clk),
		.rst_n (rst_n),
		.bm (bm1.chan)
	);

	assign bm0.start = bm_start[0];
	assign bm1.start = bm_start[1];
	assign bm0.to_mem = bm_to_mem[0];
	assign bm1.to_mem = bm_to_mem[1];
	assign bm0.table_ptr = bm_table_ptr[0];
	assign bm1.table_ptr = bm_table_ptr[1];
	assign bm0.drq = drive_dma_request[0];
	assign bm1.drq = drive_dma_request[1];
	assign bm0.rdata = mem_rdata;
	assign bm1.rdata = mem_rdata;
	assign bm0.ack = mem_ack && q.busy && !q.gnt;
	assign bm1.ack = mem_ack && q.busy && q.gnt;
	assign busmaster_channel_status = {bm1.active, bm0.active};
	assign drive_dma_ack = {bm1.dma_ack, bm0.dma_ack};
	// Grant is locked while a memory cycle is outstanding
	assign mem_req = q.busy;
	assign mem_fetch = q.gnt ? bm1.fetch : bm0.fetch;
	assign mem_write = q.gnt ? bm1.wr : bm0.wr;
	assign mem_addr = q.gnt ? bm1.addr : bm0.addr;

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		d = q;
		d.rdy_s1 = drive_ready_in;
		d.rdy_s2 = q.rdy_s1;
		d.din_s1 = drive_data_in;
		d.din_s2 = q.din_s1;
		d.ack = 1'b0;
		d.fwd = 1'b0;

		if (!q.busy && (bm0.req || bm1.req))
		begin
			d.busy = 1'b1;
			d.gnt = !bm0.req;
		end
		else if (q.busy && mem_ack)
			d.busy = 1'b0;

		if (rd_valid && rd_ready)
		begin
			d.buf_rp = !q.buf_rp;
			d.buf_cnt = q.buf_cnt - 2'h1;
		end

		// Capture read data in the first recovery clock: the synchroniser
		// then shows the pins from the clock before the last strobe clock, the first one at width 2
		if (q.st == pic_pkg::E_RECOV && q.cnt == q.recov && q.is_read)
		begin
			if (q.half)
				d.acc[31:16] = q.din_s2;
			else if (q.is_data)
				d.acc[15:0] = q.din_s2;
			else
				d.acc[7:0] = q.din_s2[7:0];
		end

		unique case (q.st)
			pic_pkg::E_IDLE:
				if (start_ok)
				begin
					if (n_ctl && n_off != pic_pkg::CTL_ALT_STATUS)
					begin
						// Reserved offsets answer at once, offset 3 goes
						// to the ISA side
						d.ack = 1'b1;
						d.fwd = n_off == pic_pkg::CTL_FLOPPY;
						if (!io_write && n_off != pic_pkg::CTL_FLOPPY)
						begin
							d.buf_word[q.buf_wp] = 32'h0000_0000;
							d.buf_wp = !q.buf_wp;
							d.buf_cnt = d.buf_cnt + 2'h1;
						end
					end
					else
					begin
						// Startup latency sets up select and address
						d.st = pic_pkg::E_SETUP;
						d.cnt = pic_pkg::SETUP_CYC;
					end
				end
			pic_pkg::E_SETUP:
				if (q.cnt == 4'h1)
				begin
					d.st = pic_pkg::E_STROBE;
					d.cnt = q.width;
				end
				else
					d.cnt = q.cnt - 4'h1;
			pic_pkg::E_STROBE:
				if (q.cnt == 4'h1)
				begin
					// Sample point: ready high adds nothing
					if (q.rdy_s2[q.ch] || q.force_rdy)
					begin
						d.st = pic_pkg::E_RECOV;
						d.cnt = q.recov;
					end
					else
						d.st = pic_pkg::E_WAIT;
				end
				else
					d.cnt = q.cnt - 4'h1;
			pic_pkg::E_WAIT:
				// Synchroniser adds at least two clocks
				if (q.rdy_s2[q.ch])
				begin
					d.st = pic_pkg::E_RECOV;
					d.cnt = q.recov;
				end
			pic_pkg::E_RECOV:
				if (q.cnt == 4'h1)
				begin
					if (q.two_half && !q.half)
					begin
						// Second half runs straight on
						d.half = 1'b1;
						d.dout = q.wdata[31:16];
						d.st = pic_pkg::E_STROBE;
						d.cnt = q.width;
					end
					else
					begin
						d.ack = 1'b1;
						if (q.is_read)
						begin
							d.buf_word[q.buf_wp] = d.acc;
							d.buf_wp = !q.buf_wp;
							d.buf_cnt = d.buf_cnt + 2'h1;
						end
						// Shutdown latency holds the lines
						d.st = pic_pkg::E_HOLD;
						d.cnt = pic_pkg::SHUTDOWN_CYC;
					end
				end
				else
					d.cnt = q.cnt - 4'h1;
			pic_pkg::E_HOLD:
				if (start_ok && q.is_data && n_data && n_ch == q.ch)
				begin
					// Lines are still set up
					d.st = pic_pkg::E_STROBE;
					d.cnt = d.width;
				end
				else if (q.cnt == 4'h1)
					d.st = pic_pkg::E_IDLE;
				else
					d.cnt = q.cnt - 4'h1;
		endcase

		if (start_ok && d.st != q.st
			&& (q.st == pic_pkg::E_IDLE || q.st == pic_pkg::E_HOLD))
		begin
			// Load the access parameters
			d.ch = n_ch;
			d.is_ctl = n_ctl;
			d.reg_off = n_off;
			d.is_data = n_data;
			d.is_read = !io_write;
			d.half = 1'b0;
			d.acc = 32'h0000_0000;
			d.wdata = io_wdata;
			// Width of the drive transfer
			d.dout = n_data ? io_wdata[15:0] : {8'h00, io_wdata[7:0]};
			d.two_half = n_data && io_dword
				&& n_cfg[pic_pkg::TIM_DWORD + pic_pkg::TIM_DRIVE_STEP * n_drv];
			d.force_rdy = n_cfg[pic_pkg::TIM_RDY_FORCE
				+ pic_pkg::TIM_DRIVE_STEP * n_drv];
			d.width = n_fast ? {2'b00, n_stb_sel} + pic_pkg::STROBE_MIN_CYC
				: pic_pkg::CMP_STROBE_CYC;
			d.recov = n_fast ? {2'b00, n_rcv_sel} + pic_pkg::RECOV_MIN_CYC
				: pic_pkg::CMP_RECOV_CYC;
			// ISA recovery only counts while no fast mode is on
			if (!io_write && n_data && isa_recovery_en && !any_fast)
				d.recov = d.recov + pic_pkg::ISA_RECOV_CYC;
			if (io_write && !n_ctl && n_off == pic_pkg::REG_DRIVE_HEAD)
				d.drive_sel[n_ch] = io_wdata[pic_pkg::DRIVE_SEL_BIT];
		end

		d.rd_stb = (d.st == pic_pkg::E_STROBE || d.st == pic_pkg::E_WAIT)
			&& d.is_read;
		d.wr_stb = (d.st == pic_pkg::E_STROBE || d.st == pic_pkg::E_WAIT)
			&& !d.is_read;
		d.oe = d.st != pic_pkg::E_IDLE && d.st != pic_pkg::E_HOLD
			&& !d.is_read;
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs; selects stay up through startup and shutdown
	assign io_ack = q.ack;
	assign isa_forward = q.fwd;
	assign rd_valid = q.buf_cnt != 2'h0;
	assign rd_data = q.buf_word[q.buf_rp];
	assign drive_register_addr = q.reg_off;
	assign drive_data_out = q.dout;
	assign drive_data_oe = q.oe;
	assign command_block_select_n[0] = !(q.st != pic_pkg::E_IDLE
		&& !q.is_ctl && !q.ch);
	assign command_block_select_n[1] = !(q.st != pic_pkg::E_IDLE
		&& !q.is_ctl && q.ch);
	assign control_block_select_n[0] = !(q.st != pic_pkg::E_IDLE
		&& q.is_ctl && !q.ch);
	assign control_block_select_n[1] = !(q.st != pic_pkg::E_IDLE
		&& q.is_ctl && q.ch);
	assign drive_read_strobe_n[0] = !(q.rd_stb && !q.ch);
	assign drive_read_strobe_n[1] = !(q.rd_stb && q.ch);
	assign drive_write_strobe_n[0] = !(q.wr_stb && !q.ch);
	assign drive_write_strobe_n[1] = !(q.wr_stb && q.ch);

endmodule

// ==== bench/pic_ctrl_props.sv ====
/* Checker on the controller's top ports.
 Assumes a bind to pic_ctrl and one clock domain. */
`timescale 1ns/1ns
module pic_ctrl_props (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// I/O target
	input wire logic io_req,
	input wire logic [31:0] io_addr,
	input wire logic io_claim,
	input wire logic io_ack,
	input wire logic isa_forward,
	// Drive cables
	input wire logic [1:0] command_block_select_n,
	input wire logic [1:0] control_block_select_n,
	input wire logic [1:0] drive_read_strobe_n,
	input wire logic [1:0] drive_write_strobe_n,
	// Bus master
	input wire logic [1:0] busmaster_channel_status,
	input wire logic [1:0] drive_dma_ack,
	input wire logic mem_req,
	input wire logic mem_ack,
	input wire logic [31:0] mem_addr
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_claim_in_range: assert property (io_claim |-> io_req && io_addr[31:16] == 16'h0)
		else $error("claim outside decoded range");
	a_ack_one_cycle: assert property (io_ack |=> !io_ack)
		else $error("io_ack longer than one cycle");
	a_fwd_no_strobe: assert property (isa_forward |-> &drive_read_strobe_n && &drive_write_strobe_n)
		else $error("forwarded access strobed a drive");
	a_strobe_has_cs: assert property (!drive_write_strobe_n[0] |-> !(&{command_block_select_n[0], control_block_select_n[0]}))
		else $error("strobe without chip select");
	a_cs_before_strobe: assert property ($fell(drive_write_strobe_n[0]) |-> !$past(command_block_select_n[0]) || !$past(control_block_select_n[0]))
		else $error("select not set up before strobe");
	a_strobe_two_min: assert property ($fell(drive_write_strobe_n[0]) |=> !drive_write_strobe_n[0])
		else $error("strobe shorter than two clocks");
	a_dack_when_active: assert property ((drive_dma_ack & ~busmaster_channel_status) == 2'h0)
		else $error("dma ack on inactive channel");
	a_mem_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("memory request dropped early");
endmodule
bind pic_ctrl pic_ctrl_props props (.*);

// ==== bench/pic_drive_model.sv ====
/* Far side: drives on both cables and memory behind the master port.
 Assumes the bench sets ready, requests and memory latency. */
`timescale 1ns/1ns
module pic_drive_model #(parameter logic [15:0] DVAL = 16'ha55a) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Bench control
	input wire logic [1:0] ready_en,
	input wire logic [1:0] dreq_en,
	input wire logic [1:0] lat,
	// Drive pins
	input wire logic [1:0] drive_read_strobe_n,
	output logic [15:0] drive_data_in,
	output logic [1:0] drive_ready_in,
	output logic [1:0] drive_dma_request,
	// Memory port
	input wire logic mem_req,
	input wire logic mem_fetch,
	input wire logic [31:0] mem_addr,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	logic [1:0] wait_q;
	logic [31:0] word;
	// Bus floats between reads: show the inverse, not a held value
	assign drive_data_in = &drive_read_strobe_n ? ~DVAL : DVAL;
	assign drive_ready_in = ready_en;
	assign drive_dma_request = dreq_en;
	// One 4-byte region well inside 64K, table end set
	assign word = !mem_fetch ? 32'h0 : mem_addr[2] ? 32'h8000_0004 : 32'h0000_1000;
	assign mem_rdata = mem_ack ? word : ~word;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wait_q <= 2'h0;
			mem_ack <= 1'b0;
		end
		else
		begin
			mem_ack <= mem_req && !mem_ack && wait_q >= lat;
			wait_q <= mem_req && !mem_ack && wait_q < lat ? wait_q + 2'h1 : 2'h0;
		end
	end
endmodule

// ==== bench/pic_ctrl_tb.sv ====
/* Bench for pic_ctrl, one task per scenario.
 Assumes the checker is bound from its own file. */
`timescale 1ns/1ns
module pic_ctrl_tb;
	localparam logic [15:0] DVAL = 16'ha55a;
	logic clk, rst_n, io_space_en, isa_recovery_en, got, seen;
	logic io_req, io_write, io_dword, io_claim, io_ack, isa_forward;
	logic rd_valid, rd_ready, drive_data_oe, mem_req, mem_fetch;
	logic mem_write, mem_ack;
	logic [1:0][15:0] drive_timing_cfg;
	logic [1:0][3:0] second_drive_timing_cfg;
	logic [1:0][31:0] bm_table_ptr;
	logic [31:0] io_addr, io_wdata, rd_data, mem_addr, mem_rdata;
	logic [1:0] command_block_select_n, control_block_select_n, lat;
	logic [1:0] drive_read_strobe_n, drive_write_strobe_n, dreq_en;
	logic [1:0] drive_ready_in, drive_dma_request, drive_dma_ack;
	logic [1:0] bm_start, bm_to_mem, busmaster_channel_status, ready_en;
	logic [2:0] drive_register_addr;
	logic [15:0] drive_data_in, drive_data_out;
	logic [19:0] wseen;
	logic [31:0] waddr[$];
	int miscompares, checks, cyc, run, hr, width, gap, nst, nfwd;
	pic_ctrl dut (.*);
	pic_drive_model #(.DVAL(DVAL)) model (.*);
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			miscompares++;
			test_done;
		end
		if (!(drive_read_strobe_n[0] & drive_write_strobe_n[0]))
		begin
			if (run == 0)
			begin
				nst++;
				gap = hr;
			end
			run++;
			hr = 0;
		end
		else
		begin
			if (run > 0)
				width = run;
			run = 0;
			hr++;
		end
		if (isa_forward)
			nfwd++;
		if (!drive_write_strobe_n[0])
			wseen = {drive_data_oe, drive_register_addr, drive_data_out};
		if (mem_req && mem_ack && mem_write && !mem_fetch)
			waddr.push_back(mem_addr);
	end
	task automatic test_done;
		if (miscompares == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, v);
		checks++;
		if (v !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, v);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic go(input logic w, dw, input logic [31:0] a, d);
		io_write = w;
		io_dword = dw;
		io_addr = a;
		io_wdata = d;
		nst = 0;
		nfwd = 0;
		width = 0;
		io_req = 1'b1;
	endtask
	task automatic wait_ack(input int lim);
		got = 1'b0;
		for (int i = 0; i < lim && !got; i++)
		begin
			@(posedge clk);
			#1;
			got = io_ack === 1'b1;
		end
		if (got)
		begin
			@(posedge clk);
			#1;
			io_req = 1'b0;
			repeat (2) @(posedge clk);
			#1;
		end
	endtask
	task automatic acc(input logic w, dw, input logic [31:0] a, d);
		go(w, dw, a, d);
		wait_ack(200);
		chk("io_ack", 1, got);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk("cmd_sel", 2'h3, command_block_select_n);
		chk("status", 2'h0, busmaster_channel_status);
		acc(1, 0, 32'h1f2, 32'h5a);
		chk("width", pic_pkg::CMP_STROBE_CYC, width);
		chk("strobes", 1, nst);
		chk("wr_pins", 20'ha005a, wseen);
	endtask
	task automatic t_fast;
		for (int s = 0; s < 4; s++)
		begin
			drive_timing_cfg[0] = {2'h2, 2'(s), 2'h0, 2'(s), 8'h05};
			acc(1, 1, 32'h1f0, 32'h1234_5678);
			chk("width", 32'(s + 2), width);
			chk("gap", 32'(s + 1), gap);
			chk("strobes", 2, nst);
		end
		isa_recovery_en = 1'b1;
		acc(0, 1, 32'h1f0, 0);
		chk("gap", 4, gap);
		isa_recovery_en = 1'b0;
		drive_timing_cfg[0] = 16'h8004;
		acc(1, 1, 32'h1f0, 0);
		chk("strobes", 2, nst);
		chk("width", pic_pkg::CMP_STROBE_CYC, width);
	endtask
	task automatic t_drive;
		drive_timing_cfg[0] = 16'h8001;
		acc(1, 0, 32'h1f6, 32'h10);
		acc(1, 0, 32'h1f0, 0);
		chk("width", pic_pkg::CMP_STROBE_CYC, width);
		drive_timing_cfg[0] = 16'hc011;
		second_drive_timing_cfg[0] = 4'hc;
		acc(1, 0, 32'h1f0, 0);
		chk("width", 5, width);
		acc(1, 0, 32'h1f6, 0);
		acc(1, 0, 32'h1f0, 0);
		chk("width", 2, width);
		rd_ready = 1'b0;
		acc(0, 0, 32'h1f0, 0);
		chk("rd_data", DVAL, rd_data);
		rd_ready = 1'b1;
	endtask
	task automatic t_ready;
		drive_timing_cfg[0] = 16'h8001;
		ready_en = 2'h2;
		go(1, 0, 32'h1f0, 0);
		repeat (10) @(posedge clk);
		#1;
		ready_en = 2'h3;
		wait_ack(200);
		chk("wait", 1, width > 4);
		drive_timing_cfg[0] = 16'h8003;
		ready_en = 2'h2;
		acc(1, 0, 32'h1f0, 0);
		chk("width", 2, width);
		ready_en = 2'h3;
	endtask
	task automatic t_buffer;
		rd_ready = 1'b0;
		acc(0, 0, 32'h3f6, 0);
		chk("rd_valid", 1, rd_valid);
		chk("rd_byte", DVAL[7:0], rd_data[7:0]);
		acc(0, 0, 32'h3f6, 0);
		go(0, 0, 32'h3f6, 0);
		wait_ack(40);
		chk("stall", 0, got);
		rd_ready = 1'b1;
		wait_ack(200);
		chk("io_ack", 1, got);
		repeat (4) @(posedge clk);
		#1;
		chk("rd_valid", 0, rd_valid);
	endtask
	task automatic t_misc;
		acc(1, 0, 32'h3f7, 0);
		chk("forward", 1, nfwd);
		chk("strobes", 0, nst);
		acc(0, 0, 32'h3f4, 0);
		chk("strobes", 0, nst);
		io_addr = 32'h1_01f0;
		io_req = 1'b1;
		#1;
		chk("claim", 0, io_claim);
		@(posedge clk);
		#1;
		io_req = 1'b0;
	endtask
	task automatic t_bm;
		for (int c = 0; c < 2; c++)
		begin
			lat = 2'(c * 3);
			waddr.delete();
			seen = 1'b0;
			dreq_en[c] = 1'b1;
			bm_table_ptr[c] = 32'h100;
			bm_start[c] = 1'b1;
			repeat (100)
			begin
				@(posedge clk);
				#1;
				seen = seen | busmaster_channel_status[c];
			end
			chk("active", 1, seen);
			chk("words", 2, waddr.size());
			chk("addr0", 32'h1000, waddr[0]);
			chk("addr1", 32'h1002, waddr[1]);
			chk("status", 0, busmaster_channel_status[c]);
			chk("dma_ack", 0, drive_dma_ack[c]);
			bm_start[c] = 1'b0;
			dreq_en[c] = 1'b0;
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{io_space_en, isa_recovery_en, io_req, io_write, io_dword} = 5'h10;
		{io_addr, io_wdata, bm_table_ptr} = '0;
		drive_timing_cfg = {16'h8000, 16'h8000};
		second_drive_timing_cfg = '0;
		{bm_start, dreq_en, lat} = 6'h0;
		{bm_to_mem, ready_en} = 4'hf;
		rd_ready = 1'b1;
		rst_n = 1'b0;
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_reset;
		t_fast;
		t_drive;
		t_ready;
		t_buffer;
		t_misc;
		t_bm;
		test_done;
	end
endmodule
